// ==== inc/cfg_ctrl_pkg.sv ====
package cfg_ctrl_pkg;

    // power-on reset interval
    localparam int POR_TIME_US      = 100;
    localparam int CLK_PERIOD_NS    = 40;
    localparam int POR_CYCLES       = (POR_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // reset values of the driven lines
    localparam logic RST_STATUS_LOW  = 1'b1;
    localparam logic RST_DONE_LOW    = 1'b1;
    localparam logic RST_CHAIN_OUT_N = 1'b1;
    localparam logic RST_SELECT_N    = 1'b1;

    // configuration mode selection
    typedef enum logic [1:0] {
        MODE_PASSIVE,
        MODE_ACTIVE_SERIAL,
        MODE_ACTIVE_PARALLEL
    } cfg_mode_t;

    // open-drain pin as drive value plus enable
    typedef struct packed {
        logic drv_low;
        logic oe;
    } od_pin_t;

    // progress reported by the loader datapath
    typedef struct packed {
        logic data_done;
        logic data_error;
    } load_evt_t;

endpackage : cfg_ctrl_pkg

// ==== hdl/config_status_chain_control.sv ====
`timescale 1ns/1ps
// Function
// - hold status line low after power-up, release after power-on interval
// - pull status line low on a configuration receive error
// - external low on status during config or init enters error state
// - after init, ignore status transitions, no reconfiguration from them
// - hold complete line low before and during configuration data reception
// - release complete line when all data arrived cleanly, init begins
// - initialize and enter user mode only after complete reads high
// - external low on complete after init has no effect
// - accept configuration only while chain enable input is low (checked only when loading starts, not during the load)
// - drive chain enable output low once complete reads high and init begins
// - when option off, chain output pin is user i/o after configuration
// - active serial mode: select output enables serial memory while reading
// - active parallel mode: same select is flash chip enable
// - request low discards configuration, resets, tri-states user pins
// - request returning high starts a new configuration cycle
module config_status_chain_control
    import cfg_ctrl_pkg::*;
#(
    parameter int POR_COUNT = cfg_ctrl_pkg::POR_CYCLES
) (
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    // request and chain enable
    input  wire logic                   config_request_n,
    input  wire logic                   chain_enable_in_n,
    // mode and options
    input  wire cfg_ctrl_pkg::cfg_mode_t mode,
    input  wire logic                   chain_out_enable_opt,
    // loader datapath events
    input  wire cfg_ctrl_pkg::load_evt_t load_evt,
    input  wire logic                   init_finished,
    // status line
    input  wire logic                   config_status_n_in,
    output logic                        config_status_n_out,
    output logic                        config_status_n_oe,
    // complete line
    input  wire logic                   config_complete_in,
    output logic                        config_complete_out,
    output logic                        config_complete_oe,
    // chain enable output
    output logic                        chain_enable_out_n,
    output logic                        chain_out_is_user_io,
    // memory select
    output logic                        memory_select_n,
    // core control
    output logic                        loading,
    output logic                        user_mode,
    output logic                        user_pins_hiz,
    output logic                        clear_config
);

    typedef enum logic [2:0] {
        ST_POR,
        ST_RESET,
        ST_WAIT_CE,
        ST_LOAD,
        ST_DONE_WAIT,
        ST_INIT,
        ST_USER,
        ST_ERROR
    } state_t;

    localparam int CW = $clog2(POR_COUNT + 1);

    state_t          state_ff;
    state_t          nxt_state;
    logic [CW-1:0]   por_cnt_ff;
    logic            req_n_ff;
    logic            status_low_ff;
    logic            done_low_ff;
    logic            ceo_n_ff;
    logic            sel_n_ff;

    // decoded conditions
    wire por_expired   = (por_cnt_ff == CW'(POR_COUNT));
    wire req_low       = !config_request_n;
    wire req_rise      = config_request_n && !req_n_ff;
    wire in_config     = (state_ff == ST_LOAD) || (state_ff == ST_DONE_WAIT)
                         || (state_ff == ST_INIT);
    wire ext_status    = in_config && !config_status_n_in && !status_low_ff;
    wire active_mode   = (mode == MODE_ACTIVE_SERIAL) || (mode == MODE_ACTIVE_PARALLEL);

    // power-on interval counter; saturates at the limit
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            por_cnt_ff <= '0;
        end else if (!por_expired) begin
            por_cnt_ff <= por_cnt_ff + CW'(1);
        end
    end

    // request edge tracker for the rising edge
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            req_n_ff <= 1'b1;
        end else begin
            req_n_ff <= config_request_n;
        end
    end

    // next state; request low overrides everything but power-on
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_POR:       if (por_expired) nxt_state = ST_RESET;
            ST_RESET:     if (config_request_n) nxt_state = ST_WAIT_CE;
            ST_WAIT_CE:   if (!chain_enable_in_n) nxt_state = ST_LOAD;
            ST_LOAD: begin
                if (load_evt.data_error || ext_status) begin
                    nxt_state = ST_ERROR;
                end else if (load_evt.data_done) begin
                    nxt_state = ST_DONE_WAIT;
                end
            end
            ST_DONE_WAIT: begin
                if (ext_status) begin
                    nxt_state = ST_ERROR;
                end else if (config_complete_in) begin
                    nxt_state = ST_INIT;
                end
            end
            ST_INIT: begin
                if (ext_status) begin
                    nxt_state = ST_ERROR;
                end else if (init_finished) begin
                    nxt_state = ST_USER;
                end
            end
            ST_USER:      nxt_state = ST_USER;
            ST_ERROR:     nxt_state = ST_ERROR;
            default:      nxt_state = ST_RESET;
        endcase
        if (state_ff != ST_POR && req_low) begin
            nxt_state = ST_RESET;
        end
        if (state_ff != ST_POR && !req_low && req_rise) begin
            nxt_state = ST_WAIT_CE;
        end
    end

    // state register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_ff <= ST_POR;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // registered pin drivers, computed from the next state to avoid a lag
    wire nxt_status_low = (nxt_state == ST_POR) || (nxt_state == ST_ERROR)
                          || (nxt_state == ST_RESET);
    wire nxt_done_low   = (nxt_state != ST_DONE_WAIT) && (nxt_state != ST_INIT)
                          && (nxt_state != ST_USER);
    wire nxt_ceo_n      = (nxt_state != ST_USER) && (nxt_state != ST_INIT);
    wire nxt_sel_n      = !((nxt_state == ST_LOAD) && active_mode);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            status_low_ff <= RST_STATUS_LOW;
            done_low_ff   <= RST_DONE_LOW;
            ceo_n_ff      <= RST_CHAIN_OUT_N;
            sel_n_ff      <= RST_SELECT_N;
        end else begin
            status_low_ff <= nxt_status_low;
            done_low_ff   <= nxt_done_low;
            ceo_n_ff      <= nxt_ceo_n;
            sel_n_ff      <= nxt_sel_n;
        end
    end

    // open-drain lines: only ever drive low, enable while pulling
    assign config_status_n_out   = 1'b0;
    assign config_status_n_oe    = status_low_ff;
    assign config_complete_out   = 1'b0;
    assign config_complete_oe    = done_low_ff;

    // chain output becomes user i/o when option is off and config is over
    assign chain_out_is_user_io  = !chain_out_enable_opt && (state_ff == ST_USER);
    assign chain_enable_out_n    = ceo_n_ff;
    assign memory_select_n       = sel_n_ff;

    assign loading       = (state_ff == ST_LOAD);
    assign user_mode     = (state_ff == ST_USER);
    assign user_pins_hiz = (state_ff != ST_USER);
    assign clear_config  = (state_ff == ST_RESET) || (state_ff == ST_POR);

    // checks
    por_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state_ff == ST_POR) |-> config_status_n_oe)
        else $error("status not held low during power-on");
    err_pull_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state_ff == ST_LOAD && load_evt.data_error && config_request_n)
        |=> config_status_n_oe)
        else $error("status not pulled low on error");
    ext_status_a: assert property (@(posedge ref_clk) disable iff (rst)
        (ext_status && config_request_n && !req_rise) |=> (state_ff == ST_ERROR))
        else $error("external status low ignored");
    user_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state_ff == ST_USER && config_request_n) |=> (state_ff == ST_USER))
        else $error("user mode left without request");
    done_low_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state_ff == ST_LOAD) |-> config_complete_oe)
        else $error("complete released while loading");
    done_rel_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state_ff == ST_LOAD && load_evt.data_done && !load_evt.data_error
         && !ext_status && config_request_n && !req_rise) |=> !config_complete_oe)
        else $error("complete not released after data");
    init_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(state_ff == ST_INIT) |-> $past(config_complete_in))
        else $error("init began with complete low");
    ce_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(loading) |-> !$past(chain_enable_in_n))
        else $error("load started while chain disabled");
    ceo_user_a: assert property (@(posedge ref_clk) disable iff (rst)
        user_mode |-> !chain_enable_out_n)
        else $error("chain output high in user mode");
    sel_load_a: assert property (@(posedge ref_clk) disable iff (rst)
        (loading && active_mode) |-> !memory_select_n)
        else $error("memory not selected during active load");
    req_reset_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state_ff != ST_POR && req_low) |=> (clear_config && user_pins_hiz))
        else $error("request low did not reset");

    reach_user_c:  cover property (@(posedge ref_clk) disable iff (rst) $rose(user_mode));
    reach_err_c:   cover property (@(posedge ref_clk) disable iff (rst) state_ff == ST_ERROR);
    reconfig_c:    cover property (@(posedge ref_clk) disable iff (rst)
        user_mode ##1 req_low);
    ext_status_c:  cover property (@(posedge ref_clk) disable iff (rst) ext_status);

endmodule : config_status_chain_control

// ==== test/cfg_far_side.sv ====
`timescale 1ns/1ps
// far side of the control lines: pull-ups, a slower chained device, a host
module cfg_far_side (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // device pull-down enables
    input  wire logic       status_oe,
    input  wire logic       complete_oe,
    // commanded external pulls
    input  wire logic       pull_status,
    input  wire logic       pull_complete,
    input  wire logic [1:0] complete_hold,
    // wired levels
    output logic            status_level,
    output logic            complete_level
);
    logic [1:0] hold_ff;
    // a slower chained device keeps complete low a while after ours lets go
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hold_ff <= 2'h0;
        end else if (complete_oe) begin
            hold_ff <= complete_hold;
        end else if (hold_ff != 2'h0) begin
            hold_ff <= hold_ff - 2'h1;
        end
    end
    // pull-up lines: a released line reads high, never the last driven value
    assign status_level   = ~(status_oe | pull_status);
    assign complete_level = ~(complete_oe | pull_complete | (hold_ff != 2'h0));
endmodule : cfg_far_side

// ==== test/config_status_chain_control_bench.sv ====
`timescale 1ns/1ps
module config_status_chain_control_bench;
    import cfg_ctrl_pkg::*;
    localparam int POR = 8;
    logic ref_clk = 0, rst = 1, req_n = 1, ce_n = 1, opt = 1, fin = 0, p_st = 0, p_cd = 0;
    logic       st_oe, st_out, cd_oe, cd_out, st_lvl, cd_lvl, ce_out_n, uio;
    logic       sel_n, loading, user_mode, hiz, clr;
    logic [1:0] hold = 2'h0;
    cfg_mode_t  mode = MODE_PASSIVE;
    load_evt_t  evt = '0;
    int         n_errors = 0, cmp_count = 0, seed = 91, c;
    wire logic [3:0] mon = {loading, user_mode, st_oe, ce_out_n};

    // 25 MHz
    always #20 ref_clk = ~ref_clk;

    config_status_chain_control #(.POR_COUNT(POR)) u_config_status_chain_control (
        .ref_clk(ref_clk), .rst(rst), .config_request_n(req_n), .chain_enable_in_n(ce_n),
        .mode(mode), .chain_out_enable_opt(opt), .load_evt(evt), .init_finished(fin),
        .config_status_n_in(st_lvl), .config_status_n_out(st_out), .config_status_n_oe(st_oe),
        .config_complete_in(cd_lvl), .config_complete_out(cd_out), .config_complete_oe(cd_oe),
        .chain_enable_out_n(ce_out_n), .chain_out_is_user_io(uio), .memory_select_n(sel_n),
        .loading(loading), .user_mode(user_mode), .user_pins_hiz(hiz), .clear_config(clr));

    cfg_far_side u_cfg_far_side (
        .ref_clk(ref_clk), .rst(rst), .status_oe(st_oe), .complete_oe(cd_oe),
        .pull_status(p_st), .pull_complete(p_cd), .complete_hold(hold),
        .status_level(st_lvl), .complete_level(cd_lvl));

    // inputs always move 1 ns after the rising edge
    task step;
        @(posedge ref_clk);
        #1;
    endtask : step

    // every checked value is a single line or flag
    task check(input string what, input logic seen, input logic exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task print_verdict;
        $display("comparisons %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    // bounded wait; running out counts as a mismatch and ends the run
    task wait_bit(input int k, input logic v);
        for (int i = 0; i < 60 && mon[k] !== v; i++) step;
        if (mon[k] !== v) begin
            n_errors++;
            $display("CHECK FAILED wait on monitor bit %0d expected %b seen %b", k, v, mon[k]);
            print_verdict;
        end
    endtask : wait_bit

    // only the active modes enable the external memory
    function automatic logic exp_sel_n(input cfg_mode_t m);
        return (m == MODE_PASSIVE);
    endfunction : exp_sel_n

    // pulse request low, hold chain enable off a while, then start loading
    task start_load;
        req_n = 0;
        step;
        step;
        req_n = 1;
        ce_n  = 1;
        repeat (3) step;
        check("loading without enable", loading, 0);
        ce_n = 0;
        wait_bit(3, 1);
    endtask : start_load

    task load_cycle(input cfg_mode_t m);
        mode = m;
        opt  = 1'($random(seed));
        hold = 2'($random(seed));
        start_load;
        step;
        check("complete oe in load", cd_oe, 1);
        check("status drive value", st_out, 0);
        check("complete drive value", cd_out, 0);
        check("select in load", sel_n, exp_sel_n(m));
        evt.data_done = 1;
        step;
        evt = '0;
        check("complete oe released", cd_oe, 0);
        check("select after load", sel_n, 1);
        repeat (hold) begin
            check("user mode early", user_mode, 0);
            check("chain out early", ce_out_n, 1);
            step;
        end
        wait_bit(0, 0);
        check("user mode in init", user_mode, 0);
        fin = 1;
        step;
        fin = 0;
        check("user mode", user_mode, 1);
        check("pins driven", hiz, 0);
        check("chain pin user io", uio, !opt);
    endtask : load_cycle

    initial begin
        repeat (8) step;
        check("status oe in reset", st_oe, 1);
        rst = 0;
        for (c = 0; c < 40 && st_oe === 1'b1; c++) step;
        check("por length", (c >= POR && c <= POR + 3), 1);
        for (int m = 0; m < 3; m++) begin
            load_cycle(cfg_mode_t'(m));
            p_st = 1;
            p_cd = 1;
            repeat (2 + ($random(seed) & 3)) step;
            check("user mode kept", user_mode, 1);
            check("status oe in user", st_oe, 0);
            p_st = 0;
            p_cd = 0;
            req_n = 0;
            step;
            check("user mode cleared", user_mode, 0);
            check("config cleared", clr, 1);
            check("pins hiz", hiz, 1);
        end
        // receive error, reported together with a done pulse
        start_load;
        evt = '{data_done: 1'b1, data_error: 1'b1};
        step;
        evt = '0;
        step;
        check("status oe on error", st_oe, 1);
        check("complete oe on error", cd_oe, 1);
        check("no user mode on error", user_mode, 0);
        // outside party pulls status low mid-load
        start_load;
        repeat ($random(seed) & 3) step;
        p_st = 1;
        step;
        step;
        p_st = 0;
        step;
        check("status oe after ext low", st_oe, 1);
        check("loading stopped", loading, 0);
        print_verdict;
    end
endmodule : config_status_chain_control_bench
